// *** rtl/pdsc_regs.vh ***
// register offsets, field positions and reset values of the pll divider and sync config bank
`ifndef PDSC_REGS_VH
`define PDSC_REGS_VH
`define PDSC_ADDR_W            7
`define PDSC_OFF_DIV_CFG       7'h0d
`define PDSC_OFF_LOCK_STAT     7'h0e
`define PDSC_OFF_BAND_STAT     7'h0f
`define PDSC_OFF_SYNC_CFG      7'h10
`define PDSC_DIV_CFG_MASK      8'hdf
`define PDSC_SYNC_CFG_MASK     8'hcf
`define PDSC_DIV_CFG_RST       8'hd9
`define PDSC_SYNC_CFG_RST      8'h48
`define PDSC_CTL_DIV_HI        7
`define PDSC_CTL_DIV_LO        6
`define PDSC_XPT_EN_BIT        4
`define PDSC_VCO_DIV_HI        3
`define PDSC_VCO_DIV_LO        2
`define PDSC_LOOP_DIV_HI       1
`define PDSC_LOOP_DIV_LO       0
`define PDSC_LOCK_BIT          7
`define PDSC_SYNC_EN_BIT       7
`define PDSC_SYNC_RATE_BIT     6
`define PDSC_SYNC_EDGE_BIT     3
`define PDSC_SYNC_AVG_HI       2
`define PDSC_SYNC_AVG_LO       0
`endif

// *** rtl/pdsc_sync2.v ***
// two-flop synchroniser for status levels arriving from the analog pll
`timescale 1ns/1ps
`default_nettype none
module pdsc_sync2 #(
   parameter W = 1
) (
   input  wire         mclk_in,
   input  wire         rst_in,
   input  wire [W-1:0] d_in,
   output reg  [W-1:0] q_out
);
   reg [W-1:0] meta; // first stage, read only by q_out

   // plain two-stage chain; status is quasi-static so no coherency stage is needed
   always @(posedge mclk_in) begin
      if (rst_in) begin
         meta  <= {W{1'b0}};
         q_out <= {W{1'b0}};
      end else begin
         meta  <= d_in;
         q_out <= meta;
      end
   end
endmodule // pdsc_sync2
`default_nettype wire

// *** rtl/pdsc_bank.v ***
// register bank holding pll divider settings, pll status readback and sync configuration
`timescale 1ns/1ps
`default_nettype none
`include "pdsc_regs.vh"
// Function
// - controller clock divider: 2,4,8,16, default 16
// - cross-point controller enable, resets to one
// - vco divider: 1,1,4,4, resets to 10
// - loop divider: 2,4,8,16, resets to 01
// - lock bit reads live tracking status
// - four-bit vco control voltage readback
// - six-bit vco band readback
// - sync enable, resets to zero
// - sync rate: fifo rate or data rate
// - sync edge select, rising by default
// - averaging code 000 means one sample
// - averaging codes double sample count up to 128
module pdsc_bank (
   input  wire        mclk_in,            // converter main clock
   input  wire        rst_in,             // synchronous reset, active high
   input  wire        wr_en_in,           // one-cycle write strobe from serial port
   input  wire        rd_en_in,           // one-cycle read strobe from serial port
   input  wire [6:0]  addr_in,            // register address
   input  wire [7:0]  wdata_in,           // write data
   output reg  [7:0]  rdata_out,          // read data, valid the cycle after rd_en_in
   input  wire        pll_locked_in,      // async lock level from pll
   input  wire [3:0]  vco_voltage_in,     // async coded vco control voltage
   input  wire [5:0]  vco_band_in,        // async selected vco band
   output reg  [4:0]  controller_clock_divider_out, // ratio value 2..16
   output reg         xpt_ctrl_en_out,    // cross-point controller enable
   output reg  [2:0]  vco_output_divider_out,       // ratio value 1 or 4
   output reg  [4:0]  loop_feedback_divider_out,    // ratio value 2..16
   output reg         sync_en_out,        // sync logic enable
   output reg         sync_data_rate_out, // 1 = data rate, 0 = fifo reset rate
   output reg         sync_rising_out,    // 1 = rising edge, 0 = falling edge
   output reg  [7:0]  sync_avg_count_out  // samples averaged, 1..128
);
   reg  [7:0] div_cfg;   // stored divider config
   reg  [7:0] sync_cfg;  // stored sync config
   wire       lock_s;    // synchronised lock level
   wire [3:0] volt_s;    // synchronised voltage code
   wire [5:0] band_s;    // synchronised band
   reg  [7:0] next_rdata; // read mux result

   // 2-bit code to power-of-two ratio 2..16, shared by two dividers
   function [4:0] pow2_ratio;
      input [1:0] code;
      begin
         pow2_ratio = 5'h02 << code;
      end
   endfunction

   // status pins come from the analog side: two flops before any read
   pdsc_sync2 #(.W(11)) u_sync (
      .mclk_in (mclk_in),
      .rst_in  (rst_in),
      .d_in    ({pll_locked_in, vco_voltage_in, vco_band_in}),
      .q_out   ({lock_s, volt_s, band_s})
   );

   // writable registers; unassigned bits are masked so they stay zero
   always @(posedge mclk_in) begin
      if (rst_in) begin
         div_cfg  <= `PDSC_DIV_CFG_RST;
         sync_cfg <= `PDSC_SYNC_CFG_RST;
      end else if (wr_en_in) begin
         if (addr_in == `PDSC_OFF_DIV_CFG)
            div_cfg <= wdata_in & `PDSC_DIV_CFG_MASK;
         else if (addr_in == `PDSC_OFF_SYNC_CFG)
            sync_cfg <= wdata_in & `PDSC_SYNC_CFG_MASK;
      end
   end

   // read mux; status registers show live synchronised values
   always @* begin
      case (addr_in)
         `PDSC_OFF_DIV_CFG:   next_rdata = div_cfg;
         `PDSC_OFF_LOCK_STAT: next_rdata = {lock_s, 3'h0, volt_s};
         `PDSC_OFF_BAND_STAT: next_rdata = {2'h0, band_s};
         `PDSC_OFF_SYNC_CFG:  next_rdata = sync_cfg;
         default:             next_rdata = 8'h00; // unmapped reads zero
      endcase
   end

   // decoded reset values of the field outputs; they must agree with what
   // the reset bytes of the two writable registers decode to, otherwise the
   // outputs would step once in the first cycle after reset
   localparam [4:0] CTL_DIV_RST  = 5'h10; // code 11 gives divide by 16
   localparam       XPT_EN_RST   = 1'b1;  // cross-point controller on
   localparam [2:0] VCO_DIV_RST  = 3'h4;  // code 10 gives divide by 4
   localparam [4:0] LOOP_DIV_RST = 5'h04; // code 01 gives divide by 4
   localparam       SYNC_EN_RST  = 1'b0;  // sync logic off
   localparam       SYNC_RT_RST  = 1'b1;  // data rate
   localparam       SYNC_EDG_RST = 1'b1;  // rising edge
   localparam [7:0] AVG_RST      = 8'h01; // code 000 gives one sample

   // read data register: loads only on a read strobe, so a host that
   // samples late still sees the byte it asked for
   // status bytes are captured here, so a read is a snapshot of the
   // synchronised levels, not a live wire into the analog side
   always @(posedge mclk_in) begin
      if (rst_in) begin
         rdata_out <= 8'h00; // nothing read yet
      end else if (rd_en_in) begin
         rdata_out <= next_rdata;
      end
   end

   // controller clock divider ratio
   // outputs lag the register by one cycle, accepted to keep them flop-driven;
   // the analog divider only sees a quasi-static level, so the lag is harmless
   always @(posedge mclk_in) begin
      if (rst_in) begin
         controller_clock_divider_out <= CTL_DIV_RST; // default 16
      end else begin
         controller_clock_divider_out <=
            pow2_ratio(div_cfg[`PDSC_CTL_DIV_HI:`PDSC_CTL_DIV_LO]);
      end
   end

   // cross-point controller enable
   // a plain copy of the stored bit, registered for a clean output
   always @(posedge mclk_in) begin
      if (rst_in) begin
         xpt_ctrl_en_out <= XPT_EN_RST; // controller active after reset
      end else begin
         xpt_ctrl_en_out <= div_cfg[`PDSC_XPT_EN_BIT];
      end
   end

   // vco output divider ratio
   // high code bit alone picks 4, so 00/01 both give 1; the low bit is
   // stored and read back but has no effect on the ratio
   always @(posedge mclk_in) begin
      if (rst_in) begin
         vco_output_divider_out <= VCO_DIV_RST; // default 4
      end else if (div_cfg[`PDSC_VCO_DIV_HI]) begin
         vco_output_divider_out <= 3'h4; // codes 10 and 11
      end else begin
         vco_output_divider_out <= 3'h1; // codes 00 and 01
      end
   end

   // loop feedback divider ratio
   // shares the power-of-two decode with the controller divider
   always @(posedge mclk_in) begin
      if (rst_in) begin
         loop_feedback_divider_out <= LOOP_DIV_RST; // default 4
      end else begin
         loop_feedback_divider_out <=
            pow2_ratio(div_cfg[`PDSC_LOOP_DIV_HI:`PDSC_LOOP_DIV_LO]);
      end
   end

   // sync logic enable
   // off after reset so no stray sync edge is acted on before setup
   always @(posedge mclk_in) begin
      if (rst_in) begin
         sync_en_out <= SYNC_EN_RST; // sync off
      end else begin
         sync_en_out <= sync_cfg[`PDSC_SYNC_EN_BIT];
      end
   end

   // sync rate select: 1 runs at the data rate, 0 at the fifo reset rate
   always @(posedge mclk_in) begin
      if (rst_in) begin
         sync_data_rate_out <= SYNC_RT_RST; // data rate
      end else begin
         sync_data_rate_out <= sync_cfg[`PDSC_SYNC_RATE_BIT];
      end
   end

   // sync edge select: 1 starts on a rising edge, 0 on a falling edge
   always @(posedge mclk_in) begin
      if (rst_in) begin
         sync_rising_out <= SYNC_EDG_RST; // rising edge
      end else begin
         sync_rising_out <= sync_cfg[`PDSC_SYNC_EDGE_BIT];
      end
   end

   // sync averaging count
   // the count doubles with every code step, so a shift of one is enough;
   // the eight-bit output holds the largest count of 128 exactly
   always @(posedge mclk_in) begin
      if (rst_in) begin
         sync_avg_count_out <= AVG_RST; // one sample
      end else begin
         sync_avg_count_out <=
            8'h01 << sync_cfg[`PDSC_SYNC_AVG_HI:`PDSC_SYNC_AVG_LO];
      end
   end
endmodule // pdsc_bank
`default_nettype wire

// *** bench/pdsc_bank_checker.sv ***
// port assertions for the pll divider and sync config bank
`timescale 1ns/1ps
`default_nettype none
module pdsc_checker (
   input wire logic       mclk_in, rst_in, wr_en_in, rd_en_in,
   input wire logic [6:0] addr_in,
   input wire logic [7:0] wdata_in, rdata_out, sync_avg_count_out,
   input wire logic [4:0] controller_clock_divider_out, loop_feedback_divider_out,
   input wire logic [2:0] vco_output_divider_out,
   input wire logic       xpt_ctrl_en_out, sync_en_out, sync_data_rate_out, sync_rising_out
);
   default clocking cb @(posedge mclk_in); endclocking
   default disable iff (rst_in);
   wire wd = wr_en_in && addr_in == 7'h0d;  // divider byte write
   wire ws = wr_en_in && addr_in == 7'h10;  // sync byte write
   a_ctl_div: assert property (wd |-> ##2 controller_clock_divider_out == 5'h2 << $past(wdata_in[7:6], 2)) else $error("ctl div");
   a_xpt_en: assert property (wd |-> ##2 xpt_ctrl_en_out == $past(wdata_in[4], 2)) else $error("xpt");
   a_vco_div: assert property (wd |-> ##2 vco_output_divider_out == ($past(wdata_in[3], 2) ? 3'h4 : 3'h1)) else $error("vco div");
   a_loop_div: assert property (wd |-> ##2 loop_feedback_divider_out == 5'h2 << $past(wdata_in[1:0], 2)) else $error("loop div");
   a_sync_bits: assert property (ws |-> ##2 {sync_en_out, sync_data_rate_out, sync_rising_out} == {$past(wdata_in[7:6], 2), $past(wdata_in[3], 2)}) else $error("sync");
   a_avg_count: assert property (ws |-> ##2 sync_avg_count_out == 8'h1 << $past(wdata_in[2:0], 2)) else $error("avg");
   a_fields_hold: assert property (!wr_en_in && !$past(wr_en_in) |=> $stable({controller_clock_divider_out, loop_feedback_divider_out, sync_avg_count_out})) else $error("hold");
   a_rdata_hold: assert property (!rd_en_in |=> $stable(rdata_out)) else $error("rdata hold");
   a_unmapped_zero: assert property (rd_en_in && (addr_in < 7'h0d || addr_in > 7'h10) |=> rdata_out == 8'h0) else $error("unmapped");
   a_unused_bits: assert property (rd_en_in && addr_in == 7'h10 |=> rdata_out[5:4] == 2'h0) else $error("unused");
endmodule // pdsc_checker
bind pdsc_bank pdsc_checker i_pdsc_checker (.*);
`default_nettype wire

// *** bench/testbench.sv ***
// self-checking bench for the pll divider and sync config bank
`timescale 1ns/1ps
`default_nettype none
module testbench;
   logic mclk_in = 0, rst_in = 1, wr_en_in = 0, rd_en_in = 0, pll_locked_in = 0;
   logic [6:0] addr_in = 0;
   logic [7:0] wdata_in = 0, rdata_out, sync_avg_count_out, d, m_div = 8'hd9, m_sync = 8'h48;
   logic [3:0] vco_voltage_in = 0;
   logic [5:0] vco_band_in = 0;
   logic [4:0] controller_clock_divider_out, loop_feedback_divider_out;
   logic [2:0] vco_output_divider_out;
   logic xpt_ctrl_en_out, sync_en_out, sync_data_rate_out, sync_rising_out;
   int n_mismatch = 0, n_tests = 0;
   always #12.5 mclk_in = ~mclk_in;
   pdsc_bank i_pdsc_bank (.*);
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      n_tests++;
      if (got !== exp) begin
         n_mismatch++;
         $display("wrong value at %0t: %h vs %h", $time, got, exp);
      end
   endtask
   // one bus access; read data has landed when this returns
   task automatic acc(input logic w, input logic [6:0] a, input logic [7:0] v);
      @(negedge mclk_in) {wr_en_in, rd_en_in, addr_in, wdata_in} <= {w, !w, a, v};
      @(negedge mclk_in) {wr_en_in, rd_en_in} <= 2'b00;
   endtask
   // compare field outputs and readback with the model bytes
   task automatic outs;
      repeat (2) @(negedge mclk_in);
      chk({controller_clock_divider_out, xpt_ctrl_en_out, vco_output_divider_out, loop_feedback_divider_out}, {5'h2 << m_div[7:6], m_div[4], m_div[3] ? 3'h4 : 3'h1, 5'h2 << m_div[1:0]});
      chk({sync_en_out, sync_data_rate_out, sync_rising_out, sync_avg_count_out}, {m_sync[7:6], m_sync[3], 8'h1 << m_sync[2:0]});
      acc(0, 7'h0d, 0); chk(rdata_out, m_div & 8'hdf);
      acc(0, 7'h10, 0); chk(rdata_out, m_sync & 8'hcf);
   endtask
   task automatic test_done;
      $display("mismatches %0d, checks %0d", n_mismatch, n_tests);
      if (n_mismatch == 0 && n_tests > 0) $display("All tests passed");
      else $display("Some tests failed");
      $finish;
   endtask
   initial begin #100000; n_mismatch++; test_done; end
   initial begin
      d = $urandom(32'h8d562749);
      repeat (8) @(negedge mclk_in);
      rst_in <= 0;
      outs;
      for (int i = 0; i < 8; i++) begin
         d = $urandom; d[2:0] = i; acc(1, 7'h10, d); m_sync = d;
         d = $urandom; d[7:6] = i; d[3] = i; d[1:0] = i >> 1; acc(1, 7'h0d, d); m_div = d;
         outs;
      end
      acc(1, 7'h0e, 8'hff); acc(1, 7'h20, 8'hff); outs;
      acc(0, 7'h20, 0); chk(rdata_out, 0);
      for (int i = 0; i < 3; i++) begin
         {pll_locked_in, vco_voltage_in, vco_band_in} = $urandom; repeat (3) @(negedge mclk_in);
         acc(0, 7'h0e, 0); chk(rdata_out, {pll_locked_in, 3'h0, vco_voltage_in});
         acc(0, 7'h0f, 0); chk(rdata_out, {2'h0, vco_band_in});
      end
      rst_in <= 1; @(negedge mclk_in) rst_in <= 0; m_div = 8'hd9; m_sync = 8'h48;
      outs;
      test_done;
   end
endmodule // testbench
`default_nettype wire
